// ### design/edhcs_top.sv
// dma bus handover arbiter and internal memory configuration scan
`timescale 1ns/10ps
module edhcs_top (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        proc_clock_output,
  input  wire logic        dma_req,
  input  wire logic        ext_cycle_busy,
  input  wire logic        refresh_owed,
  input  wire logic        ext_access_req,
  input  wire logic [4:0]  select_strobes_in_n,
  input  wire logic [3:0]  byte_write_strobes_in_n,
  input  wire logic        config_sense_input,
  output logic             dma_grant,
  output logic             addr_float,
  output logic [4:0]       select_strobes_n,
  output logic [3:0]       byte_write_strobes_n,
  output logic             ext_access_stall,
  output logic             bus_hold,
  output logic             write_data0_line,
  output logic             refresh_data1_line,
  output logic [31:2]      muxed_address_data_lines,
  output logic             scan_drive,
  output logic             ext_config_req,
  output logic             cfg_valid,
  output logic             boot_start,
  output logic [5:0][2:0]  phase_len,
  output logic [3:0][4:0]  strobe_coef,
  output logic             late_write,
  output logic [6:0]       refresh_interval,
  output logic [3:0]       cycle_time
);
  // ****************************************************************
  // crossings
  // ****************************************************************
  logic link_rst_n;
  logic req_s;
  logic busy_s;
  logic hold_s;
  logic sense_s;
  logic busy_reg;
  logic link_hold_reg;

  edhcs_sync #(.WIDTH(1), .NEG_EDGE(1'b1)) u_rst_sync (
    .clk (proc_clock_output),
    .d   (rst_n),
    .q   (link_rst_n)
  );
  edhcs_sync #(.WIDTH(1), .NEG_EDGE(1'b1)) u_req_sync (
    .clk (proc_clock_output),
    .d   (dma_req),
    .q   (req_s)
  );
  edhcs_sync #(.WIDTH(1), .NEG_EDGE(1'b1)) u_busy_sync (
    .clk (proc_clock_output),
    .d   (busy_reg),
    .q   (busy_s)
  );
  edhcs_sync #(.WIDTH(1), .NEG_EDGE(1'b0)) u_hold_sync (
    .clk (core_clk),
    .d   (link_hold_reg),
    .q   (hold_s)
  );
  edhcs_sync #(.WIDTH(1), .NEG_EDGE(1'b0)) u_sense_sync (
    .clk (core_clk),
    .d   (config_sense_input),
    .q   (sense_s)
  );

  // ****************************************************************
  // arbiter, falling edges of the clock output
  // ****************************************************************
  typedef enum logic [2:0] {ARB_IDLE, ARB_WAIT_BUS, ARB_FLOAT, ARB_GRANTED, ARB_RELEASE,
                            ARB_HOLDOFF} edhcs_arb_t;
  edhcs_arb_t arb_reg;
  edhcs_arb_t arb_next;
  logic [1:0] fall_cnt_reg;
  logic [1:0] fall_cnt_next;
  logic       grant_next;
  logic       float_reg;
  logic       float_next;
  logic [1:0] rise_cnt_reg;
  logic [1:0] rise_cnt_next;

  // grant only hands over the external pins; on-chip memory stays private
  always_comb
  begin
    arb_next      = arb_reg;
    fall_cnt_next = fall_cnt_reg;
    grant_next    = dma_grant;
    case (arb_reg)
      ARB_IDLE:
        if (req_s)
          arb_next = busy_s ? ARB_WAIT_BUS : ARB_FLOAT;
      ARB_WAIT_BUS:
        if (!busy_s)
          arb_next = ARB_FLOAT;
      ARB_FLOAT:
        if (float_reg)
        begin
          arb_next   = ARB_GRANTED;
          grant_next = 1'b1;
        end
      ARB_GRANTED:
        if (!req_s)
        begin
          arb_next      = ARB_RELEASE;
          fall_cnt_next = 2'h1;
        end
      ARB_RELEASE:
        if (fall_cnt_reg == edhcs_pkg::RELEASE_FALL_EDGES)
        begin
          arb_next   = ARB_HOLDOFF;
          grant_next = 1'b0;
        end
        else
          fall_cnt_next = fall_cnt_reg + 2'h1;
      ARB_HOLDOFF:
        if (!float_reg)
          arb_next = ARB_IDLE;
      default:
        arb_next = ARB_IDLE;
    endcase
  end

  always_ff @(negedge proc_clock_output)
  begin
    if (!link_rst_n)
    begin
      arb_reg       <= ARB_IDLE;
      fall_cnt_reg  <= 2'h0;
      dma_grant     <= 1'b0;
      link_hold_reg <= 1'b0;
    end
    else
    begin
      arb_reg       <= arb_next;
      fall_cnt_reg  <= fall_cnt_next;
      dma_grant     <= grant_next;
      link_hold_reg <= (arb_next != ARB_IDLE) && (arb_next != ARB_WAIT_BUS);
    end
  end

  // address float, counted on rising edges of the clock output
  always_comb
  begin
    float_next    = float_reg;
    rise_cnt_next = 2'h0;
    if (arb_reg == ARB_FLOAT && !float_reg)
    begin
      rise_cnt_next = rise_cnt_reg + 2'h1;
      if (rise_cnt_next == edhcs_pkg::FLOAT_RISE_EDGES)
        float_next = 1'b1;
    end
    else if (arb_reg == ARB_HOLDOFF && float_reg)
    begin
      rise_cnt_next = rise_cnt_reg + 2'h1;
      if (rise_cnt_next == edhcs_pkg::RESUME_RISE_EDGES)
        float_next = 1'b0;
    end
  end

  always_ff @(posedge proc_clock_output)
  begin
    if (!link_rst_n)
    begin
      float_reg    <= 1'b0;
      rise_cnt_reg <= 2'h0;
    end
    else
    begin
      float_reg    <= float_next;
      rise_cnt_reg <= rise_cnt_next;
    end
  end
  assign addr_float = float_reg;

  // ****************************************************************
  // core side gating of strobes and external access
  // ****************************************************************
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      busy_reg             <= 1'b0;
      bus_hold             <= 1'b0;
      select_strobes_n     <= 5'h1f;
      byte_write_strobes_n <= 4'hf;
      ext_access_stall     <= 1'b0;
    end
    else
    begin
      busy_reg             <= ext_cycle_busy | refresh_owed;
      bus_hold             <= hold_s;
      select_strobes_n     <= hold_s ? 5'h1f : select_strobes_in_n;
      byte_write_strobes_n <= hold_s ? 4'hf : byte_write_strobes_in_n;
      ext_access_stall     <= hold_s & ext_access_req;
    end
  end

  // ****************************************************************
  // configuration scan after reset
  // ****************************************************************
  typedef enum logic [1:0] {SC_WINDOW, SC_LOAD, SC_BOOT_WAIT, SC_DONE} edhcs_scan_t;
  localparam logic [7:0] RUN_FIRST  = 8'(edhcs_pkg::SCAN_START_CLK);
  localparam logic [7:0] RUN_END    = 8'(edhcs_pkg::SCAN_START_CLK + edhcs_pkg::SCAN_CLKS);
  localparam logic [7:0] PRE_SAMPLE = 8'(edhcs_pkg::SCAN_START_CLK + 1);
  localparam logic [7:0] WIN_LAST   = 8'(edhcs_pkg::SCAN_WINDOW_CLKS - 1);
  localparam logic [7:0] LAG        = 8'(edhcs_pkg::SYNC_LAG_CLKS);

  edhcs_scan_t scan_reg;
  edhcs_scan_t scan_next;
  logic [7:0]  win_reg;
  logic [7:0]  win_next;
  logic [31:0] lines_reg;
  logic [31:0] lines_next;
  logic        drive_next;
  logic [4:0]  hit_reg;
  logic [4:0]  hit_next;
  logic        found_reg;
  logic        found_next;
  logic        ext_next;
  logic        valid_next;
  logic        boot_next;
  logic [7:0]  rel;
  logic [7:0]  probe;
  logic [4:0]  cfg_idx;

  always_comb
  begin
    scan_next  = scan_reg;
    win_next   = win_reg;
    lines_next = lines_reg;
    drive_next = scan_drive;
    hit_next   = hit_reg;
    found_next = found_reg;
    ext_next   = ext_config_req;
    valid_next = cfg_valid;
    boot_next  = 1'b0;
    rel        = win_reg - RUN_FIRST;
    probe      = rel - LAG;
    case (scan_reg)
      SC_WINDOW:
      begin
        win_next = win_reg + 8'h01;
        // lines drop in turn, write data 0 first
        if (win_reg >= RUN_FIRST && win_reg < RUN_END && rel[0] == 1'b0)
        begin
          drive_next           = 1'b1;
          lines_next[rel[5:1]] = 1'b0;
        end
        if (win_reg == RUN_END)
        begin
          drive_next = 1'b0;
          lines_next = '1;
        end
        // first read: low before any drop means external configuration
        if (win_reg == PRE_SAMPLE && !sense_s)
          ext_next = 1'b1;
        // second read onwards: first line whose drop pulled the sense low
        if (!ext_next && !found_reg && win_reg > PRE_SAMPLE && win_reg <= RUN_END + 8'h01
            && probe[0] == 1'b0 && !sense_s)
        begin
          found_next = 1'b1;
          hit_next   = probe[5:1];
        end
        if (win_reg == WIN_LAST)
          scan_next = SC_LOAD;
      end
      SC_LOAD:
      begin
        valid_next = 1'b1;
        scan_next  = SC_BOOT_WAIT;
      end
      SC_BOOT_WAIT:
        if (!hold_s)
        begin
          boot_next = 1'b1;
          scan_next = SC_DONE;
        end
      SC_DONE:
        scan_next = SC_DONE;
      default:
        scan_next = SC_WINDOW;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      scan_reg       <= SC_WINDOW;
      win_reg        <= 8'h00;
      lines_reg      <= 32'hffffffff;
      scan_drive     <= 1'b0;
      hit_reg        <= 5'h00;
      found_reg      <= 1'b0;
      ext_config_req <= 1'b0;
      cfg_valid      <= 1'b0;
      boot_start     <= 1'b0;
    end
    else
    begin
      scan_reg       <= scan_next;
      win_reg        <= win_next;
      lines_reg      <= lines_next;
      scan_drive     <= drive_next;
      hit_reg        <= hit_next;
      found_reg      <= found_next;
      ext_config_req <= ext_next;
      cfg_valid      <= valid_next;
      boot_start     <= boot_next;
    end
  end
  assign write_data0_line         = lines_reg[0];
  assign refresh_data1_line       = lines_reg[1];
  assign muxed_address_data_lines = lines_reg[31:2];

  // only 16 positions select a preset; anything else keeps the default
  assign cfg_idx = (found_reg && (hit_reg <= edhcs_pkg::CFG_LAST_LOW_IDX)) ? hit_reg
                   : edhcs_pkg::CFG_DEFAULT_IDX;

  edhcs_cfg_rom u_rom (
    .clk              (core_clk),
    .idx              (cfg_idx),
    .phase_len        (phase_len),
    .strobe_coef      (strobe_coef),
    .late_write       (late_write),
    .refresh_interval (refresh_interval),
    .cycle_time       (cycle_time)
  );

  // ****************************************************************
  // checks
  // ****************************************************************
  grant_needs_float_a: assert property (@(negedge proc_clock_output) disable iff (!link_rst_n)
    $rose(dma_grant) |-> float_reg) else $error("grant without floated bus");
  grant_drop_two_a: assert property (@(negedge proc_clock_output) disable iff (!link_rst_n)
    (arb_reg == ARB_GRANTED && !req_s) |=> dma_grant ##1 dma_grant ##1 !dma_grant) else $error("grant drop timing");
  resume_holdoff_a: assert property (@(negedge proc_clock_output) disable iff (!link_rst_n)
    $fell(dma_grant) |-> float_reg) else $error("bus resumed too early");
  strobes_idle_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $past(hold_s) |-> (select_strobes_n == 5'h1f && byte_write_strobes_n == 4'hf)) else $error("strobe active");
  busy_blocks_a: assert property (@(negedge proc_clock_output) disable iff (!link_rst_n)
    (arb_reg == ARB_WAIT_BUS && busy_s) |=> !dma_grant && arb_reg != ARB_FLOAT) else $error("cycle cut short");
  stall_during_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (hold_s && ext_access_req) |=> ext_access_stall) else $error("access not stalled");
  boot_after_dma_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    boot_start |-> !$past(hold_s) && cfg_valid) else $error("boot during dma");
  scan_step_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (scan_reg == SC_WINDOW && win_reg == RUN_FIRST) |=> !lines_reg[0] && lines_reg[1]
      ##2 !lines_reg[1] && lines_reg[2]) else $error("scan step order");
  window_len_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(scan_drive) |-> scan_drive [*8]) else $error("scan ended early");
  default_cfg_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!found_reg && scan_reg == SC_LOAD) |=> cycle_time == 4'hc) else $error("default not used");
endmodule // edhcs_top

// ### design/edhcs_pkg.sv
// constants shared by the dma handover and configuration scan block
package edhcs_pkg;
  // ****************************************************************
  // configuration scan timing, in input clock periods
  // ****************************************************************
  localparam int unsigned CORE_CLK_PERIOD_PS = 5000;  // input clock period
  localparam int unsigned SCAN_WINDOW_CLKS   = 144;   // whole internal scan window
  localparam int unsigned SCAN_CLKS          = 64;    // active scan inside the window
  localparam int unsigned SCAN_STEP_CLKS     = 2;     // spacing of successive line drops
  localparam int unsigned SCAN_START_CLK     = 40;    // scan start inside the window
  localparam int unsigned SCAN_LINES         = 32;    // write data 0, refresh data 1, address 2..31
  localparam int unsigned SYNC_LAG_CLKS      = 3;     // drop to synchronised sense sample
  localparam int unsigned WIN_CNT_W          = 8;
  // ****************************************************************
  // preset table layout
  // ****************************************************************
  localparam int unsigned CFG_IDX_W          = 5;
  localparam logic [4:0]  CFG_DEFAULT_IDX    = 5'h1f; // top address line, also tied high
  localparam logic [4:0]  CFG_LAST_LOW_IDX   = 5'h0f; // presets 0..15 plus the default
  localparam int unsigned PHASE_W            = 3;     // one to four half clock periods
  localparam int unsigned COEF_W             = 5;
  localparam int unsigned CYC_W              = 4;
  localparam int unsigned REFRESH_W          = 7;
  localparam logic [6:0]  REFRESH_CLKS       = 7'h48; // 72 input clocks
  localparam logic [6:0]  REFRESH_NONE       = 7'h00;
  // ****************************************************************
  // handover edge counts on the processor clock output
  // ****************************************************************
  localparam logic [1:0]  FLOAT_RISE_EDGES   = 2'h2;  // float after sampled request
  localparam logic [1:0]  RELEASE_FALL_EDGES = 2'h2;  // grant drop after removal sample
  localparam logic [1:0]  RESUME_RISE_EDGES  = 2'h2;  // bus resumes after grant drop
endpackage

// ### design/edhcs_sync.sv
// two flip-flop synchroniser, rising or falling edge
`timescale 1ns/10ps
module edhcs_sync #(
  parameter int unsigned WIDTH    = 1,
  parameter bit          NEG_EDGE = 1'b0
) (
  input  wire logic             clk,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg;

  // refuse a zero width
  if (WIDTH == 0)
  begin : g_bad_width
    $error("synchroniser width must be at least one");
  end

  // first stage is read only by the second
  if (NEG_EDGE)
  begin : g_fall
    always_ff @(negedge clk)
    begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
  else
  begin : g_rise
    always_ff @(posedge clk)
    begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule // edhcs_sync

// ### design/edhcs_cfg_rom.sv
// preset memory timing table with registered read
`timescale 1ns/10ps
module edhcs_cfg_rom (
  input  wire logic                                        clk,
  input  wire logic [edhcs_pkg::CFG_IDX_W-1:0]             idx,
  output logic      [5:0][edhcs_pkg::PHASE_W-1:0]          phase_len,
  output logic      [3:0][edhcs_pkg::COEF_W-1:0]           strobe_coef,
  output logic                                             late_write,
  output logic      [edhcs_pkg::REFRESH_W-1:0]             refresh_interval,
  output logic      [edhcs_pkg::CYC_W-1:0]                 cycle_time
);
  typedef struct packed {
    logic [5:0][2:0] ph;
    logic [3:0][4:0] co;
    logic            late;
    logic            rf;
    logic [3:0]      cyc;
  } edhcs_row_t;

  // one row: phases one..six, coefficients s1..s4, write type, refresh, cycle
  function automatic edhcs_row_t row(input logic [17:0] p, input logic [19:0] c,
                                     input logic l, input logic r, input logic [3:0] y);
    edhcs_row_t e;
    e.ph   = p; // phase one stays at index 5
    e.co   = c; // s1 stays at index 3
    e.late = l;
    e.rf   = r;
    e.cyc  = y;
    return e;
  endfunction

  edhcs_row_t sel;

  // ****************************************************************
  // table lookup
  // ****************************************************************
  always_comb
  begin
    case (idx)
      5'h00:   sel = row({3'h1,3'h1,3'h1,3'h1,3'h1,3'h1}, {5'h1e,5'h01,5'h03,5'h05}, 1'b1, 1'b1, 4'h3);
      5'h01:   sel = row({3'h1,3'h2,3'h1,3'h1,3'h1,3'h2}, {5'h1e,5'h01,5'h02,5'h07}, 1'b1, 1'b1, 4'h4);
      5'h02:   sel = row({3'h1,3'h2,3'h1,3'h1,3'h2,3'h3}, {5'h1e,5'h01,5'h02,5'h07}, 1'b1, 1'b1, 4'h5);
      5'h03:   sel = row({3'h2,3'h3,3'h1,3'h1,3'h2,3'h3}, {5'h1e,5'h01,5'h03,5'h08}, 1'b1, 1'b1, 4'h6);
      5'h04:   sel = row({3'h1,3'h1,3'h1,3'h1,3'h1,3'h1}, {5'h03,5'h01,5'h02,5'h03}, 1'b0, 1'b1, 4'h3);
      5'h05:   sel = row({3'h1,3'h1,3'h2,3'h1,3'h2,3'h1}, {5'h05,5'h01,5'h02,5'h03}, 1'b0, 1'b1, 4'h4);
      5'h06:   sel = row({3'h2,3'h1,3'h2,3'h1,3'h3,3'h1}, {5'h06,5'h01,5'h02,5'h03}, 1'b0, 1'b1, 4'h5);
      5'h07:   sel = row({3'h2,3'h2,3'h2,3'h1,3'h3,3'h2}, {5'h07,5'h01,5'h03,5'h04}, 1'b0, 1'b1, 4'h6);
      5'h08:   sel = row({3'h1,3'h1,3'h1,3'h1,3'h1,3'h1}, {5'h1e,5'h01,5'h02,5'h03}, 1'b0, 1'b0, 4'h3);
      5'h09:   sel = row({3'h1,3'h1,3'h2,3'h1,3'h2,3'h1}, {5'h1e,5'h02,5'h05,5'h09}, 1'b0, 1'b0, 4'h4);
      5'h0a:   sel = row({3'h2,3'h2,3'h2,3'h2,3'h4,3'h2}, {5'h1e,5'h02,5'h03,5'h08}, 1'b1, 1'b1, 4'h7);
      5'h0b:   sel = row({3'h3,3'h3,3'h3,3'h3,3'h3,3'h3}, {5'h1e,5'h02,5'h04,5'h0d}, 1'b1, 1'b1, 4'h9);
      5'h0c:   sel = row({3'h1,3'h1,3'h2,3'h1,3'h2,3'h1}, {5'h04,5'h01,5'h02,5'h03}, 1'b0, 1'b1, 4'h4);
      5'h0d:   sel = row({3'h2,3'h1,3'h2,3'h1,3'h2,3'h2}, {5'h05,5'h01,5'h02,5'h03}, 1'b0, 1'b1, 4'h5);
      5'h0e:   sel = row({3'h2,3'h2,3'h2,3'h1,3'h3,3'h2}, {5'h06,5'h01,5'h03,5'h04}, 1'b0, 1'b1, 4'h6);
      5'h0f:   sel = row({3'h2,3'h1,3'h2,3'h3,3'h3,3'h3}, {5'h08,5'h01,5'h02,5'h03}, 1'b0, 1'b1, 4'h7);
      // default preset, also any index outside the table
      default: sel = row({3'h4,3'h4,3'h4,3'h4,3'h4,3'h4}, {5'h1f,5'h1e,5'h1e,5'h12}, 1'b1, 1'b1, 4'hc);
    endcase
  end

  // registered read port
  always_ff @(posedge clk)
  begin
    phase_len        <= sel.ph;
    strobe_coef      <= sel.co;
    late_write       <= sel.late;
    refresh_interval <= sel.rf ? edhcs_pkg::REFRESH_CLKS : edhcs_pkg::REFRESH_NONE;
    cycle_time       <= sel.cyc;
  end
endmodule // edhcs_cfg_rom

// ### dv/edhcs_dma_model.sv
// external dma controller model driving the asynchronous bus request
`timescale 1ns/10ps
module edhcs_dma_model #(
  parameter int unsigned REQ_DELAY_NS = 3,
  parameter int unsigned REFRESH_NS   = 360  // one refresh interval of 72 input clocks
) (
  input  wire logic want,
  input  wire logic dma_grant,
  output logic      dma_req,
  output logic      tenure_long
);
  realtime grant_t;

  // ****************************************************************
  // request line
  // ****************************************************************
  // request moves off both clocks, so sampling must synchronise it
  initial dma_req = 1'b0;
  always @(want)
  begin
    dma_req <= #(REQ_DELAY_NS) want;
  end
  // ****************************************************************
  // tenure watch
  // ****************************************************************
  // a tenure past one refresh interval would leave refresh duty to this master
  initial
  begin
    grant_t     = 0;
    tenure_long = 1'b0;
  end
  always @(posedge dma_grant)
  begin
    grant_t = $realtime;
  end
  always @(negedge dma_grant)
  begin
    if ($realtime - grant_t > REFRESH_NS)
      tenure_long = 1'b1;
  end
endmodule // edhcs_dma_model

// ### dv/testbench.sv
// self-checking bench for the dma handover and configuration scan block
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin fail_count++; $display("MISMATCH %s exp %0h got %0h", nm, exp, got); end end
module testbench;
  logic             core_clk = 1'b0;
  logic             proc_clock_output = 1'b0;
  logic             rst_n = 1'b0;
  logic             want = 1'b0;
  logic             dma_req;
  logic             ext_cycle_busy = 1'b0;
  logic             refresh_owed = 1'b0;
  logic             ext_access_req = 1'b0;
  logic [4:0]       sel_in_n = 5'h00;
  logic [3:0]       bwr_in_n = 4'h0;
  logic [5:0]       sense_mode = 6'h20;
  logic             dma_grant, addr_float, ext_access_stall, bus_hold, wrd0, rfd1;
  logic [4:0]       select_strobes_n;
  logic [3:0]       byte_write_strobes_n;
  logic [31:2]      addr_lines;
  logic             scan_drive, ext_config_req, cfg_valid, late_write, boot_start, tenure_long;
  logic [5:0][2:0]  phase_len;
  logic [3:0][4:0]  strobe_coef;
  logic [6:0]       refresh_interval;
  logic [3:0]       cycle_time;
  logic [31:0]      lines_bus;
  int               fail_count = 0;
  int               checks = 0;
  // ****************************************************************
  // clocks, sense wiring, instances
  // ****************************************************************
  always #2.5 core_clk = ~core_clk;
  initial #1.7 forever #6 proc_clock_output = ~proc_clock_output;
  assign lines_bus = {addr_lines, rfd1, wrd0};
  edhcs_dma_model i_dma (.want(want), .dma_grant(dma_grant), .dma_req(dma_req), .tenure_long(tenure_long));
  edhcs_top i_dut (
    .core_clk(core_clk), .rst_n(rst_n), .proc_clock_output(proc_clock_output), .dma_req(dma_req),
    .ext_cycle_busy(ext_cycle_busy), .refresh_owed(refresh_owed), .ext_access_req(ext_access_req),
    .select_strobes_in_n(sel_in_n), .byte_write_strobes_in_n(bwr_in_n),
    .config_sense_input(sense_mode == 6'h20 ? 1'b1 : sense_mode == 6'h21 ? 1'b0 : lines_bus[sense_mode[4:0]]),
    .dma_grant(dma_grant), .addr_float(addr_float), .select_strobes_n(select_strobes_n),
    .byte_write_strobes_n(byte_write_strobes_n), .ext_access_stall(ext_access_stall), .bus_hold(bus_hold),
    .write_data0_line(wrd0), .refresh_data1_line(rfd1), .muxed_address_data_lines(addr_lines),
    .scan_drive(scan_drive), .ext_config_req(ext_config_req), .cfg_valid(cfg_valid), .boot_start(boot_start),
    .phase_len(phase_len), .strobe_coef(strobe_coef), .late_write(late_write),
    .refresh_interval(refresh_interval), .cycle_time(cycle_time));
  // ****************************************************************
  // scenarios
  // ****************************************************************
  // reset with a sense wiring, check the scan and the adopted preset
  task automatic scan_case(input logic [5:0] mode, input logic [17:0] ph, input logic [19:0] cf,
                           input logic lw, input logic [6:0] rf, input logic [3:0] cyc, input logic ext);
    int n;
    @(posedge core_clk);
    sense_mode <= mode;
    rst_n <= 1'b0;
    repeat (8) @(posedge core_clk);
    #1 `CHK("lines_idle", 32'hffffffff, lines_bus)
    @(posedge core_clk);
    rst_n <= 1'b1;
    for (n = 0; n < 200 && wrd0 !== 1'b0; n++) @(posedge core_clk);
    #1 `CHK("scan_drive", 1'b1, scan_drive)
    for (n = 0; n < 10 && rfd1 !== 1'b0; n++) @(posedge core_clk);
    `CHK("drop_gap", 2, n)
    for (n = 0; n < 300 && cfg_valid !== 1'b1; n++) @(posedge core_clk);
    #1 `CHK("scan_end", 32'hffffffff, lines_bus)
    `CHK("ext_cfg", ext, ext_config_req)
    `CHK("phase_len", ph, phase_len)
    `CHK("strobe_coef", cf, strobe_coef)
    `CHK("late_write", lw, late_write)
    `CHK("refresh", rf, refresh_interval)
    `CHK("cycle_time", cyc, cycle_time)
  endtask
  // plain handover: float, strobes parked, stall, release timing
  task automatic dma_handover();
    int n;
    @(posedge core_clk);
    want <= 1'b1;
    for (n = 0; n < 200 && dma_grant !== 1'b1; n++) @(posedge core_clk);
    #1 `CHK("float", 1'b1, addr_float)
    @(posedge core_clk);
    ext_access_req <= 1'b1;
    repeat (6) @(posedge core_clk);
    #1 `CHK("sel_off", 5'h1f, select_strobes_n)
    `CHK("bwr_off", 4'hf, byte_write_strobes_n)
    `CHK("stall", 1'b1, ext_access_stall)
    `CHK("hold_on", 1'b1, bus_hold)
    @(posedge core_clk);
    want <= 1'b0;
    ext_access_req <= 1'b0;
    @(negedge proc_clock_output);
    #1 `CHK("grant_held", 1'b1, dma_grant)
    for (n = 0; n < 8 && dma_grant !== 1'b0; n++) @(negedge proc_clock_output);
    #1 `CHK("grant_drop", 1'b0, dma_grant)
    `CHK("float_hold", 1'b1, addr_float)
    repeat (40) @(posedge core_clk);
    #1 `CHK("float_end", 1'b0, addr_float)
    `CHK("sel_back", 5'h00, select_strobes_n)
    `CHK("hold_off", 1'b0, bus_hold)
    `CHK("stall_end", 1'b0, ext_access_stall)
  endtask
  // request while a cycle and refresh are owed waits for them
  task automatic dma_busy();
    int n;
    @(posedge core_clk);
    ext_cycle_busy <= 1'b1;
    refresh_owed <= 1'b1;
    repeat (4) @(posedge core_clk);
    want <= 1'b1;
    repeat (80) @(posedge core_clk);
    #1 `CHK("no_grant", 1'b0, dma_grant)
    @(posedge core_clk);
    ext_cycle_busy <= 1'b0;
    refresh_owed <= 1'b0;
    for (n = 0; n < 200 && dma_grant !== 1'b1; n++) @(posedge core_clk);
    #1 `CHK("late_grant", 1'b1, dma_grant)
    @(posedge core_clk);
    want <= 1'b0;
    repeat (60) @(posedge core_clk);
  endtask
  // request held through reset: grant before bootstrap, bootstrap after release
  task automatic dma_at_reset();
    int n;
    @(posedge core_clk);
    want <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    for (n = 0; n < 100 && dma_grant !== 1'b1; n++) @(posedge core_clk);
    #1 `CHK("reset_grant", 1'b1, dma_grant)
    `CHK("boot_not_yet", 1'b0, cfg_valid)
    @(posedge core_clk);
    want <= 1'b0;
    for (n = 0; n < 300 && boot_start !== 1'b1; n++) @(posedge core_clk);
    `CHK("boot_seen", 1'b1, n < 300)
    `CHK("boot_no_grant", 1'b0, dma_grant)
    `CHK("tenure", 1'b0, tenure_long)
  endtask
  // ****************************************************************
  // verdict, watchdog, main sequence
  // ****************************************************************
  task automatic print_verdict();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    print_verdict();
  end
  initial
  begin
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    scan_case(6'h20, {6{3'h4}}, {5'h1f, 5'h1e, 5'h1e, 5'h12}, 1'b1, 7'h48, 4'hc, 1'b0);
    scan_case(6'h14, {6{3'h4}}, {5'h1f, 5'h1e, 5'h1e, 5'h12}, 1'b1, 7'h48, 4'hc, 1'b0);
    scan_case(6'h21, {6{3'h4}}, {5'h1f, 5'h1e, 5'h1e, 5'h12}, 1'b1, 7'h48, 4'hc, 1'b1);
    scan_case(6'h04, {6{3'h1}}, {5'h03, 5'h01, 5'h02, 5'h03}, 1'b0, 7'h48, 4'h3, 1'b0);
    scan_case(6'h00, {6{3'h1}}, {5'h1e, 5'h01, 5'h03, 5'h05}, 1'b1, 7'h48, 4'h3, 1'b0);
    scan_case(6'h09, {3'h1,3'h1,3'h2,3'h1,3'h2,3'h1}, {5'h1e,5'h02,5'h05,5'h09}, 1'b0, 7'h00, 4'h4, 1'b0);
    scan_case(6'h1f, {6{3'h4}}, {5'h1f, 5'h1e, 5'h1e, 5'h12}, 1'b1, 7'h48, 4'hc, 1'b0);
    dma_handover();
    dma_busy();
    dma_at_reset();
    print_verdict();
  end
endmodule // testbench
